// File: hw/field_fifo_regs.svh
// Constants for the dual-port field FIFO: depth, timing and reset values
//
// Behaviour
// - Store 512k bytes, read out in order
// - Write and read ports run independently
// - Capture input byte on write clock rise
// - Write and advance only with write strobe
// - Gate low: skip store, still advance pointer
// - Write pointer clear returns address zero
// - Input flag reports free space
// - Output byte changes on read clock rise
// - Read and advance only with read strobe
// - Gate low: output off, pointer still advances
// - Read pointer clear returns address zero
// - Output flag reports stored data
// - Strap high: controls active low, else high
// - Port clocks up to 80/40 MHz; here the 20 MHz sampling clock keeps them well under clk/2 (10 MHz)
// - Strap governs all eight control signals; here only six, both clocks act on the rise
// - Global reset initialises all control logic
`ifndef FIELD_FIFO_REGS_SVH
`define FIELD_FIFO_REGS_SVH

// Memory organisation
`define FIFO_ADDR_W       19
`define FIFO_DATA_W       8
`define FIFO_DEPTH        524288
`define PTR_ZERO          19'h00000
`define PTR_STEP          19'h00001
`define FILL_FULL         19'h7ffff
`define FILL_EMPTY        19'h00000

// Sampling clock and pin clock limits
`define CLK_MHZ           20
`define PIN_CLK_FAST_MHZ  80
`define PIN_CLK_SLOW_MHZ  40

// Refresh slot spacing in clk cycles
`define REFRESH_W         6
`define REFRESH_ZERO      6'h00
`define REFRESH_STEP      6'h01

// Buffer occupancy codes
`define BUF_EMPTY         2'h0
`define BUF_ONE           2'h1
`define BUF_FULL          2'h2
`define BUF_STEP          2'h1

`endif

// File: hw/field_fifo_pkg.sv
// Types shared by the dual-port field FIFO
`include "field_fifo_regs.svh"
package field_fifo_pkg;
   typedef logic [`FIFO_ADDR_W-1:0] addr_t;
   typedef logic [`FIFO_DATA_W-1:0] byte_t;
   // One queued write: gate, address, data
   typedef struct packed {
      logic  keep;
      addr_t addr;
      byte_t data;
   } wr_entry_t;
endpackage

// File: hw/field_fifo.sv
// Dual-port field FIFO with pin sampling, write buffer and refresh slot
`timescale 1ns/1ps
`include "field_fifo_regs.svh"

// =====================================================================
// Two-entry buffer with valid/ready on both sides
module two_entry_buffer #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   logic [WIDTH-1:0] head_reg;
   logic [WIDTH-1:0] tail_reg;
   logic [1:0]       count_reg;
   logic             push;
   logic             pop;

   // Handshake decode
   assign in_ready  = (count_reg != `BUF_FULL);
   assign out_valid = (count_reg != `BUF_EMPTY);
   assign out_data  = head_reg;
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Occupancy
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count_reg <= `BUF_EMPTY;
      end else if (push && !pop) begin
         count_reg <= count_reg + `BUF_STEP;
      end else if (pop && !push) begin
         count_reg <= count_reg - `BUF_STEP;
      end
   end

   // Storage; head always holds the oldest word
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         head_reg <= '0;
         tail_reg <= '0;
      end else begin
         if (pop) begin
            head_reg <= (count_reg == `BUF_ONE) ? in_data : tail_reg;
         end else if (push && count_reg == `BUF_EMPTY) begin
            head_reg <= in_data;
         end
         if (push && (pop ? count_reg == `BUF_FULL : count_reg == `BUF_ONE)) begin
            tail_reg <= in_data;
         end
      end
   end
endmodule

// =====================================================================
// Field FIFO top
module field_fifo (
   // Clock and global reset
   input  wire logic                    clk,
   input  wire logic                    rstn,
   // Polarity strap
   input  wire logic                    polarity_strap_n,
   // Write port pins
   input  wire logic                    write_clock,
   input  wire logic [`FIFO_DATA_W-1:0] write_data_in,
   input  wire logic                    wr_strobe,
   input  wire logic                    input_mask_gate,
   input  wire logic                    write_pointer_clear,
   output logic                         input_space_flag,
   // Read port pins
   input  wire logic                    read_clock,
   input  wire logic                    rd_strobe,
   input  wire logic                    output_gate,
   input  wire logic                    read_pointer_clear,
   output logic                         output_data_flag,
   output logic [`FIFO_DATA_W-1:0]      read_data_out,
   output logic                         read_data_oe_n
);

   // ==================================================================
   // Pin synchronisers; pins are slow next to clk, so every one is
   // sampled twice and only the second stage is read. Limitation: pin
   // clocks must stay well under clk/2 here; the 80/40 MHz grades need
   // a faster sampling clock.
   localparam int PINS_W = 9 + `FIFO_DATA_W;
   logic [PINS_W-1:0] pins_s1_reg;
   logic [PINS_W-1:0] pins_s2_reg;
   logic              wck_s2;
   logic              rck_s2;
   logic              strap_s2;
   logic              wstb_s2;
   logic              wgate_s2;
   logic              wclr_s2;
   logic              rstb_s2;
   logic              rgate_s2;
   logic              rclr_s2;
   logic [`FIFO_DATA_W-1:0] wdata_s2;
   logic              wck_last_reg;
   logic              rck_last_reg;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pins_s1_reg <= '0;
         pins_s2_reg <= '0;
      end else begin
         pins_s1_reg <= {write_clock, read_clock, polarity_strap_n, wr_strobe,
                         input_mask_gate, write_pointer_clear, rd_strobe,
                         output_gate, read_pointer_clear, write_data_in};
         pins_s2_reg <= pins_s1_reg;
      end
   end

   assign {wck_s2, rck_s2, strap_s2, wstb_s2, wgate_s2, wclr_s2, rstb_s2,
           rgate_s2, rclr_s2, wdata_s2} = pins_s2_reg;

   // Edge detectors on the second stage only
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wck_last_reg <= 1'b0;
         rck_last_reg <= 1'b0;
      end else begin
         wck_last_reg <= wck_s2;
         rck_last_reg <= rck_s2;
      end
   end

   // ==================================================================
   // Polarity: strap high means active low; one XOR each on the six strobes, gates and clears
   logic wck_rise;
   logic rck_rise;
   logic wstb_act;
   logic wgate_act;
   logic wclr_act;
   logic rstb_act;
   logic rgate_act;
   logic rclr_act;
   assign wck_rise  = wck_s2 & ~wck_last_reg;
   assign rck_rise  = rck_s2 & ~rck_last_reg;
   assign wstb_act  = wstb_s2  ^ strap_s2;
   assign wgate_act = wgate_s2 ^ strap_s2;
   assign wclr_act  = wclr_s2  ^ strap_s2;
   assign rstb_act  = rstb_s2  ^ strap_s2;
   assign rgate_act = rgate_s2 ^ strap_s2;
   assign rclr_act  = rclr_s2  ^ strap_s2;

   // ==================================================================
   // Write side: edge with strobe queues a word, gate decides storing
   field_fifo_pkg::addr_t     wr_ptr_reg;
   field_fifo_pkg::addr_t     commit_ptr_reg;
   field_fifo_pkg::wr_entry_t push_entry;
   field_fifo_pkg::wr_entry_t drain_entry;
   logic wr_fire;
   logic buf_in_ready;
   logic drain_valid;
   logic drain_ready;
   logic drain_fire;

   // A strobe edge the buffer cannot take is dropped; the space flag
   // already reads busy then, so a compliant writer never hits it.
   assign wr_fire    = wck_rise & wstb_act & buf_in_ready & ~wclr_act;
   assign push_entry = '{keep: wgate_act, addr: wr_ptr_reg, data: wdata_s2};

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr_reg <= `PTR_ZERO;
      end else if (wclr_act) begin
         wr_ptr_reg <= `PTR_ZERO;
      end else if (wr_fire) begin
         wr_ptr_reg <= wr_ptr_reg + `PTR_STEP;
      end
   end

   two_entry_buffer #(
      .WIDTH ($bits(field_fifo_pkg::wr_entry_t))
   ) wr_buf (
      .clk       (clk),
      .rstn      (rstn),
      .in_valid  (wr_fire),
      .in_ready  (buf_in_ready),
      .in_data   (push_entry),
      .out_valid (drain_valid),
      .out_ready (drain_ready),
      .out_data  (drain_entry)
   );

   // ==================================================================
   // Refresh slot steals the array one cycle in 64, stalling the drain
   logic [`REFRESH_W-1:0] refresh_cnt_reg;
   logic                  refresh_slot;
   assign refresh_slot = (refresh_cnt_reg == `REFRESH_ZERO);
   assign drain_ready  = ~refresh_slot;
   assign drain_fire   = drain_valid & drain_ready;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         refresh_cnt_reg <= `REFRESH_ZERO;
      end else begin
         refresh_cnt_reg <= refresh_cnt_reg + `REFRESH_STEP;
      end
   end

   // ==================================================================
   // Memory array, 512k bytes
   logic [`FIFO_DATA_W-1:0] mem [`FIFO_DEPTH];

   always_ff @(posedge clk) begin
      if (drain_fire && drain_entry.keep) begin
         mem[drain_entry.addr] <= drain_entry.data;
      end
   end

   // Commit pointer: next address after the last word drained
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         commit_ptr_reg <= `PTR_ZERO;
      end else if (wclr_act) begin
         commit_ptr_reg <= `PTR_ZERO;
      end else if (drain_fire) begin
         commit_ptr_reg <= drain_entry.addr + `PTR_STEP;
      end
   end

   // ==================================================================
   // Read side: edge with strobe fetches and advances, gate drives pins
   field_fifo_pkg::addr_t rd_ptr_reg;
   logic rd_fire;
   assign rd_fire = rck_rise & rstb_act & ~rclr_act;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_ptr_reg <= `PTR_ZERO;
      end else if (rclr_act) begin
         rd_ptr_reg <= `PTR_ZERO;
      end else if (rd_fire) begin
         rd_ptr_reg <= rd_ptr_reg + `PTR_STEP;
      end
   end

   // Output byte and enable; enable low while the pins are driven
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         read_data_out  <= '0;
         read_data_oe_n <= 1'b1;
      end else begin
         read_data_oe_n <= ~rgate_act;
         if (rd_fire) begin
            read_data_out <= mem[rd_ptr_reg];
         end
      end
   end

   // ==================================================================
   // Flags from the pointer difference, wrapping modulo the depth
   field_fifo_pkg::addr_t wr_fill;
   field_fifo_pkg::addr_t rd_fill;
   logic space_level;
   logic data_level;
   assign wr_fill     = wr_ptr_reg - rd_ptr_reg;
   assign rd_fill     = commit_ptr_reg - rd_ptr_reg;
   assign space_level = (wr_fill != `FILL_FULL) & buf_in_ready;
   assign data_level  = (rd_fill != `FILL_EMPTY);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         input_space_flag <= 1'b0;
         output_data_flag <= 1'b0;
      end else begin
         input_space_flag <= space_level ^ strap_s2;
         output_data_flag <= data_level ^ strap_s2;
      end
   end

   // ==================================================================
   // Checks
   a_wr_clear_zero: assert property (@(posedge clk) disable iff (!rstn)
      wclr_act |=> (wr_ptr_reg == `PTR_ZERO))
      else $error("write pointer not cleared");
   a_wr_step_one: assert property (@(posedge clk) disable iff (!rstn)
      (wr_fire && !wclr_act) |=> (wr_ptr_reg == $past(wr_ptr_reg) + `PTR_STEP))
      else $error("write pointer did not step by one");
   a_wr_idle_hold: assert property (@(posedge clk) disable iff (!rstn)
      (!wck_rise && !wclr_act) |=> $stable(wr_ptr_reg))
      else $error("write pointer moved without a strobe edge");
   a_rd_clear_zero: assert property (@(posedge clk) disable iff (!rstn)
      rclr_act |=> (rd_ptr_reg == `PTR_ZERO))
      else $error("read pointer not cleared");
   a_rd_skip_step: assert property (@(posedge clk) disable iff (!rstn)
      (rd_fire && !rgate_act) |=> (rd_ptr_reg == $past(rd_ptr_reg) + `PTR_STEP)
                                  && read_data_oe_n)
      else $error("gated read did not skip");
   a_rd_data_hold: assert property (@(posedge clk) disable iff (!rstn)
      !rd_fire |=> $stable(read_data_out))
      else $error("read data changed without a read edge");
   a_out_flag_level: assert property (@(posedge clk) disable iff (!rstn)
      ##1 (output_data_flag == ($past(rd_fill) != `FILL_EMPTY) ^ $past(strap_s2)))
      else $error("output flag disagrees with fill");
   a_space_flag_full: assert property (@(posedge clk) disable iff (!rstn)
      (wr_fill == `FILL_FULL) |=> (input_space_flag == $past(strap_s2)))
      else $error("space flag shows room when full");
   a_refresh_stall: assert property (@(posedge clk) disable iff (!rstn)
      refresh_slot |-> !drain_fire ##1 !refresh_slot [*8])
      else $error("drain used the refresh slot");
endmodule

// File: dv/stream_model.sv
// Far-side stream logic model driving both ports of the field FIFO
`timescale 1ns/1ps

// =====================================================================
// Writer and reader logic on the pin side
module stream_model (
   // Sampling clock
   input  wire logic          clk,
   // Strap
   output logic               polarity_strap_n,
   // Write side
   output logic               write_clock,
   output field_fifo_pkg::byte_t write_data_in,
   output logic               wr_strobe,
   output logic               input_mask_gate,
   output logic               write_pointer_clear,
   // Read side
   output logic               read_clock,
   output logic               rd_strobe,
   output logic               output_gate,
   output logic               read_pointer_clear
);
   logic act;

   // Active control level follows the strap
   assign act = ~polarity_strap_n;

   // Idle levels from time zero
   initial begin
      polarity_strap_n = 1'b1;
      write_clock = 1'b0;
      read_clock = 1'b0;
      write_data_in = 8'h00;
      idle();
   end

   task automatic idle();
      wr_strobe = polarity_strap_n;
      rd_strobe = polarity_strap_n;
      write_pointer_clear = polarity_strap_n;
      read_pointer_clear = polarity_strap_n;
      input_mask_gate = ~polarity_strap_n;
      output_gate = ~polarity_strap_n;
   endtask

   // Wait n edges, then step off the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   // Strap only moves while the caller holds global reset
   task automatic set_strap(input logic v);
      polarity_strap_n = v;
      idle();
   endtask

   // One write frame; pin clock idles low, a period of at least 9 clk keeps it slow
   task automatic pw(input logic stb, input logic gate, input field_fifo_pkg::byte_t d);
      cyc(1);
      wr_strobe = stb ? act : ~act;
      input_mask_gate = gate ? act : ~act;
      write_data_in = d;
      cyc(4);
      write_clock = 1'b1;
      cyc(4);
      write_clock = 1'b0;
      wr_strobe = ~act;
      write_data_in = ~d; // Released bus shows no stale byte
   endtask

   // One read frame; gate is left as set so enable can be judged
   task automatic pr(input logic stb, input logic gate);
      cyc(1);
      rd_strobe = stb ? act : ~act;
      output_gate = gate ? act : ~act;
      cyc(4);
      read_clock = 1'b1;
      cyc(4);
      read_clock = 1'b0;
      rd_strobe = ~act;
      cyc(3);
   endtask

   // Pointer clear pulses, held across several sampling edges
   task automatic clr(input logic rd);
      if (rd) read_pointer_clear = act;
      else write_pointer_clear = act;
      cyc(4);
      read_pointer_clear = ~act;
      write_pointer_clear = ~act;
      cyc(4);
   endtask
endmodule

// File: dv/test_field_fifo.sv
// Self-checking testbench for the dual-port field FIFO
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
   $display("Error %0t got %h expected %h", $time, g, e); end end

module test_field_fifo;
   logic                  clk;
   logic                  rstn;
   // Pin nets, driven only by the partner model's outputs
   wire logic             strap_n, wclk, wstb, wgate, wclr, rclk, rstb, rgate, rclr;
   logic                  space_flag, data_flag, oe_n;
   field_fifo_pkg::byte_t wdata, rdata;
   int                    fails, n_tests;

   // =====================================================================
   // Partner and design
   stream_model PM (.clk(clk), .polarity_strap_n(strap_n), .write_clock(wclk),
      .write_data_in(wdata), .wr_strobe(wstb), .input_mask_gate(wgate),
      .write_pointer_clear(wclr), .read_clock(rclk), .rd_strobe(rstb),
      .output_gate(rgate), .read_pointer_clear(rclr));
   field_fifo DUT (.clk(clk), .rstn(rstn), .polarity_strap_n(strap_n),
      .write_clock(wclk), .write_data_in(wdata), .wr_strobe(wstb),
      .input_mask_gate(wgate), .write_pointer_clear(wclr), .input_space_flag(space_flag),
      .read_clock(rclk), .rd_strobe(rstb), .output_gate(rgate),
      .read_pointer_clear(rclr), .output_data_flag(data_flag),
      .read_data_out(rdata), .read_data_oe_n(oe_n));

   // 50 ns clock
   always #25 clk = ~clk;

   task automatic wrap_up();
      if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Reset held for two clocks; strap moved only in reset
   task automatic do_reset(input logic s);
      rstn = 1'b0;
      PM.set_strap(s);
      PM.cyc(2);
      rstn = 1'b1;
      PM.cyc(6);
   endtask

   // Bounded wait for stored data to be reported
   task automatic wait_data();
      int i;
      for (i = 0; i < 20 && data_flag !== ~strap_n; i++) PM.cyc(1);
      if (data_flag !== ~strap_n) begin
         fails++;
         $display("Error %0t data flag never rose", $time);
         wrap_up();
      end
   endtask

   task automatic s_reset();
      `CHK(data_flag, strap_n)
      `CHK(space_flag, ~strap_n)
      `CHK(oe_n, 1'b0)
   endtask

   // Masked, dropped and overwritten words
   task automatic s_write();
      PM.pw(1, 1, 8'ha5);
      wait_data();
      PM.pw(1, 1, 8'h3c);
      PM.clr(0);
      PM.pw(1, 0, 8'h77);
      PM.pw(0, 1, 8'h99);
      PM.pw(1, 1, 8'h5e);
      PM.pw(1, 1, 8'hf0);
      PM.cyc(8);
      `CHK(space_flag, ~strap_n)
   endtask

   task automatic s_read();
      PM.pr(1, 1);
      `CHK(rdata, 8'ha5)
      PM.pr(1, 1);
      `CHK(rdata, 8'h5e)
      PM.pr(0, 1);
      `CHK(rdata, 8'h5e)
      PM.pr(1, 1);
      `CHK(rdata, 8'hf0)
      PM.cyc(4);
      `CHK(data_flag, strap_n)
   endtask

   // Skipped read still advances the pointer
   task automatic s_skip();
      PM.clr(1);
      PM.pr(1, 0);
      `CHK(oe_n, 1'b1)
      PM.pr(1, 1);
      `CHK(rdata, 8'h5e)
      `CHK(oe_n, 1'b0)
   endtask

   // Active-high controls, global reset and idle retention
   task automatic s_polarity();
      do_reset(1'b0);
      `CHK(data_flag, 1'b0)
      `CHK(space_flag, 1'b1)
      PM.pw(1, 1, 8'h42);
      wait_data();
      PM.cyc(200);
      PM.pr(1, 1);
      `CHK(rdata, 8'h42)
      PM.cyc(4);
      `CHK(data_flag, 1'b0)
   endtask

   // =====================================================================
   // Main sequence
   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      fails = 0;
      n_tests = 0;
      do_reset(1'b1);
      s_reset();
      s_write();
      s_read();
      s_skip();
      s_polarity();
      wrap_up();
   end
endmodule
